// ===== tmss_pkg.sv
`default_nettype none
package tmss_pkg;
    localparam int NUM_X = 8;
    localparam int NUM_Y = 3;
    localparam int NUM_KEYS = 24;
    localparam int KEY_W = 5;
    localparam int LIMIT_SMALL = 16;
    localparam int LIMIT_LARGE = 24;
    localparam int DIL_W = 8;
    localparam int BURST_W = 8;
    localparam int RESULT_W = 16;
    localparam logic [RESULT_W-1:0] RESULT_MAX = 16'hFFFF;
    localparam int CLK_PERIOD_NS = 10;
    localparam int DWELL_NS = 500;
    localparam int DWELL_CYC = DWELL_NS / CLK_PERIOD_NS;
    localparam int LOW_NS = 500;
    localparam int LOW_CYC = (LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int CLAMP_NS = 1000;
    localparam int CLAMP_CYC = (CLAMP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int CNT_W = 8;
    localparam logic [23:0] ENABLE_SMALL_RESET = 24'h00FFFF;
    localparam logic [23:0] ENABLE_LARGE_RESET = 24'hFFFFFF;

    function automatic logic [KEY_W-1:0] tmss_key_num(
        input logic [1:0] y_idx,
        input logic [2:0] x_idx
    );
        tmss_key_num = {y_idx, x_idx};
    endfunction
endpackage
`default_nettype wire

// ===== tmss_key_enable.sv
`default_nettype none
module tmss_key_enable
    import tmss_pkg::*;
(
    input wire logic clk,
    input wire logic reset_n,
    input wire logic large_variant,
    input wire logic [NUM_KEYS*DIL_W-1:0] detect_integrator_limit,
    output logic [NUM_KEYS-1:0] key_enabled,
    output logic [KEY_W-1:0] enabled_count
);
    logic [NUM_KEYS-1:0] want;
    logic [NUM_KEYS-1:0] key_enabled_reg;
    logic [NUM_KEYS-1:0] key_enabled_next;
    logic [KEY_W-1:0] enabled_count_reg;
    logic [KEY_W-1:0] enabled_count_next;
    logic [KEY_W-1:0] limit;
    logic started_reg;
    logic started_next;

    ////////////////////////////////////////////////////////////////////
    always_comb begin
        limit = large_variant ? KEY_W'(LIMIT_LARGE) : KEY_W'(LIMIT_SMALL);
        started_next = 1'b1;
        enabled_count_next = '0;
        key_enabled_next = '0;
        for (int k = 0; k < NUM_KEYS; k++) begin
            want[k] = detect_integrator_limit[k*DIL_W +: DIL_W] != '0; // RQ4
        end
        if (!started_reg) begin
            // Small part enables only the first two lines, and only for the first cycle out of reset
            key_enabled_next = large_variant ? ENABLE_LARGE_RESET
                                             : ENABLE_SMALL_RESET; // RQ5
            key_enabled_next = key_enabled_next & want;
        end else begin
            // Whole load judged at once, so a swap in one load is legal
            for (int k = 0; k < NUM_KEYS; k++) begin
                if (want[k] && enabled_count_next < limit) begin // RQ2
                    key_enabled_next[k] = 1'b1;
                    enabled_count_next = enabled_count_next + 1'b1;
                end
            end
        end
        if (!started_reg) begin
            for (int k = 0; k < NUM_KEYS; k++) begin
                enabled_count_next = enabled_count_next
                    + KEY_W'(key_enabled_next[k]);
            end
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            key_enabled_reg <= '0;
            enabled_count_reg <= '0;
            started_reg <= 1'b0;
        end else begin
            key_enabled_reg <= key_enabled_next;
            enabled_count_reg <= enabled_count_next;
            started_reg <= started_next;
        end
    end

    assign key_enabled = key_enabled_reg;
    assign enabled_count = enabled_count_reg;

    a_count_limit: assert property (@(posedge clk) // RQ2
        disable iff (!reset_n)
        enabled_count_reg <= limit)
        else $error("enabled key count above limit");
endmodule
`default_nettype wire

// ===== tmss_ramp_timer.sv
`default_nettype none
module tmss_ramp_timer
    import tmss_pkg::*;
(
    input wire logic clk,
    input wire logic reset_n,
    input wire logic start,
    input wire logic zero_cross,
    output logic busy,
    output logic done,
    output logic [RESULT_W-1:0] count
);
    logic busy_reg;
    logic busy_next;
    logic done_reg;
    logic done_next;
    logic [RESULT_W-1:0] count_reg;
    logic [RESULT_W-1:0] count_next;

    ////////////////////////////////////////////////////////////////////
    always_comb begin
        busy_next = busy_reg;
        done_next = 1'b0;
        count_next = count_reg;
        if (start) begin
            busy_next = 1'b1;
            count_next = '0; // RQ13
        end else if (busy_reg) begin
            // Saturate so a missing crossing cannot hang the scan
            if (zero_cross || count_reg == RESULT_MAX) begin // RQ11 RQ13
                busy_next = 1'b0;
                done_next = 1'b1;
            end else begin
                count_next = count_reg + 1'b1;
            end
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            busy_reg <= 1'b0;
            done_reg <= 1'b0;
            count_reg <= '0;
        end else begin
            busy_reg <= busy_next;
            done_reg <= done_next;
            count_reg <= count_next;
        end
    end

    assign busy = busy_reg;
    assign done = done_reg;
    assign count = count_reg;

    a_timer_sat: assert property (@(posedge clk) disable iff (!reset_n) // RQ13
        busy_reg && !start && count_reg == RESULT_MAX |=> done_reg && !busy_reg)
        else $error("ramp timer did not stop at saturation");
    a_timer_clear: assert property (@(posedge clk) // RQ13
        disable iff (!reset_n)
        start |=> count_reg == '0 && busy_reg)
        else $error("ramp timer not cleared at start");
endmodule
`default_nettype wire

// ===== tmss_scan_sequencer.sv
`default_nettype none
// Overview of operation
// [RQ1] Keys sit on 8 drive by 3 receive grid
// [RQ2] Enabled keys capped at 16 or 24
// [RQ3] One timeslot per enabled key only; an enabled key with zero burst length gets none
// [RQ4] Zero integrator limit disables key, skips burst
// [RQ5] Small part enables first two lines at reset
// [RQ6] Start X0 Y0, drive index advances first
// [RQ7] Key number is eight times Y plus X
// [RQ8] Pulse count from key's own burst length
// [RQ9] Finish burst, convert, report, then next key
// [RQ10] Clamp receive line on each falling drive edge
// [RQ11] Clamp, then time ramp to zero crossing
// [RQ12] Fixed 500 ns dwell after rising edge
// [RQ13] Ramp timer clears at start, saturates
module tmss_scan_sequencer
    import tmss_pkg::*;
(
    input wire logic clk,
    input wire logic reset_n,
    input wire logic large_variant,
    input wire logic scan_start,
    input wire logic [tmss_pkg::NUM_KEYS*tmss_pkg::DIL_W-1:0]
        detect_integrator_limit,
    input wire logic [tmss_pkg::NUM_KEYS*tmss_pkg::BURST_W-1:0]
        burst_length_setting,
    input wire logic zero_cross,
    output logic [tmss_pkg::NUM_X-1:0] x_drive,
    output logic [tmss_pkg::NUM_Y-1:0] y_clamp,
    output logic [tmss_pkg::NUM_Y-1:0] y_select,
    output logic result_valid,
    output logic [tmss_pkg::KEY_W-1:0] result_key,
    output logic [tmss_pkg::RESULT_W-1:0] result_data,
    output logic scan_busy,
    output logic scan_done,
    output logic [tmss_pkg::KEY_W-1:0] slot_count
);
    typedef enum logic [6:0] {
        S_IDLE = 7'b0000001,
        S_PICK = 7'b0000010,
        S_HIGH = 7'b0000100,
        S_LOW = 7'b0001000,
        S_CLAMP = 7'b0010000,
        S_RAMP = 7'b0100000,
        S_DONE = 7'b1000000
    } tmss_state_e;

    tmss_state_e state_reg;
    tmss_state_e state_next;
    logic [2:0] x_reg;
    logic [2:0] x_next;
    logic [1:0] y_reg;
    logic [1:0] y_next;
    logic [BURST_W-1:0] pulse_reg;
    logic [BURST_W-1:0] pulse_next;
    logic [CNT_W-1:0] tick_reg;
    logic [CNT_W-1:0] tick_next;
    logic [KEY_W-1:0] slots_reg;
    logic [KEY_W-1:0] slots_next;
    logic valid_reg;
    logic valid_next;
    logic [KEY_W-1:0] rkey_reg;
    logic [KEY_W-1:0] rkey_next;
    logic [RESULT_W-1:0] rdata_reg;
    logic [RESULT_W-1:0] rdata_next;
    logic done_reg;
    logic done_next;
    logic [NUM_KEYS-1:0] key_enabled;
    logic [KEY_W-1:0] enabled_count;
    logic [KEY_W-1:0] cur_key;
    logic [BURST_W-1:0] cur_burst;
    logic timer_start;
    logic timer_busy;
    logic timer_done;
    logic [RESULT_W-1:0] timer_count;
    logic last_key;
    logic [KEY_W-1:0] live_count;

    ////////////////////////////////////////////////////////////////////
    tmss_key_enable u_enable (
        .clk(clk),
        .reset_n(reset_n),
        .large_variant(large_variant),
        .detect_integrator_limit(detect_integrator_limit),
        .key_enabled(key_enabled),
        .enabled_count(enabled_count)
    );

    tmss_ramp_timer u_timer (
        .clk(clk),
        .reset_n(reset_n),
        .start(timer_start),
        .zero_cross(zero_cross),
        .busy(timer_busy),
        .done(timer_done),
        .count(timer_count)
    );

    ////////////////////////////////////////////////////////////////////
    always_comb begin
        cur_key = tmss_key_num(y_reg, x_reg); // RQ7
        cur_burst = burst_length_setting[cur_key*BURST_W +: BURST_W]; // RQ8
        last_key = (cur_key == KEY_W'(NUM_KEYS - 1));
    end

    // Keys that really get a burst: enabled with a nonzero length
    always_comb begin
        live_count = '0;
        for (int k = 0; k < NUM_KEYS; k++) begin
            if (key_enabled[k]
                && burst_length_setting[k*BURST_W +: BURST_W] != '0) begin
                live_count = live_count + 1'b1;
            end
        end
    end

    always_comb begin
        state_next = state_reg;
        x_next = x_reg;
        y_next = y_reg;
        pulse_next = pulse_reg;
        tick_next = tick_reg;
        slots_next = slots_reg;
        valid_next = 1'b0;
        rkey_next = rkey_reg;
        rdata_next = rdata_reg;
        done_next = 1'b0;
        timer_start = 1'b0;
        unique case (state_reg)
            S_IDLE: begin
                if (scan_start) begin
                    x_next = '0; // RQ6
                    y_next = '0;
                    slots_next = '0;
                    state_next = S_PICK;
                end
            end
            S_PICK: begin
                if (key_enabled[cur_key] && cur_burst != '0) begin // RQ3 RQ4
                    pulse_next = cur_burst;
                    tick_next = '0;
                    slots_next = slots_reg + 1'b1;
                    state_next = S_HIGH;
                end else if (last_key) begin
                    state_next = S_DONE;
                end else if (x_reg == 3'(NUM_X - 1)) begin // RQ6
                    x_next = '0;
                    y_next = y_reg + 1'b1;
                end else begin
                    x_next = x_reg + 1'b1;
                end
            end
            S_HIGH: begin
                // Dwell is a constant so charge capture is not tunable
                if (tick_reg == CNT_W'(DWELL_CYC - 1)) begin // RQ12
                    tick_next = '0;
                    pulse_next = pulse_reg - 1'b1;
                    state_next = S_LOW;
                end else begin
                    tick_next = tick_reg + 1'b1;
                end
            end
            S_LOW: begin
                if (tick_reg == CNT_W'(LOW_CYC - 1)) begin
                    tick_next = '0;
                    state_next = (pulse_reg == '0) ? S_CLAMP : S_HIGH; // RQ9
                end else begin
                    tick_next = tick_reg + 1'b1;
                end
            end
            S_CLAMP: begin
                if (tick_reg == CNT_W'(CLAMP_CYC - 1)) begin // RQ11
                    timer_start = 1'b1;
                    state_next = S_RAMP;
                end else begin
                    tick_next = tick_reg + 1'b1;
                end
            end
            S_RAMP: begin
                if (timer_done) begin
                    valid_next = 1'b1; // RQ9
                    rkey_next = cur_key;
                    rdata_next = timer_count;
                    if (last_key) begin
                        state_next = S_DONE;
                    end else begin
                        state_next = S_PICK;
                        if (x_reg == 3'(NUM_X - 1)) begin
                            x_next = '0;
                            y_next = y_reg + 1'b1;
                        end else begin
                            x_next = x_reg + 1'b1;
                        end
                    end
                end
            end
            S_DONE: begin
                done_next = 1'b1;
                state_next = S_IDLE;
            end
            default: begin
                state_next = S_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            state_reg <= S_IDLE;
            x_reg <= '0;
            y_reg <= '0;
            pulse_reg <= '0;
            tick_reg <= '0;
            slots_reg <= '0;
            valid_reg <= 1'b0;
            rkey_reg <= '0;
            rdata_reg <= '0;
            done_reg <= 1'b0;
        end else begin
            state_reg <= state_next;
            x_reg <= x_next;
            y_reg <= y_next;
            pulse_reg <= pulse_next;
            tick_reg <= tick_next;
            slots_reg <= slots_next;
            valid_reg <= valid_next;
            rkey_reg <= rkey_next;
            rdata_reg <= rdata_next;
            done_reg <= done_next;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Pins decoded from state; only the active lines ever move
    always_comb begin
        x_drive = '0;
        y_clamp = '0;
        y_select = '0;
        if (state_reg == S_HIGH) begin
            x_drive[x_reg] = 1'b1; // RQ1
        end
        if (state_reg == S_HIGH || state_reg == S_LOW
            || state_reg == S_CLAMP || state_reg == S_RAMP) begin
            y_select[y_reg] = 1'b1;
        end
        if (state_reg == S_LOW || state_reg == S_CLAMP) begin
            y_clamp[y_reg] = 1'b1; // RQ10 RQ11
        end
    end

    assign result_valid = valid_reg;
    assign result_key = rkey_reg;
    assign result_data = rdata_reg;
    assign scan_busy = (state_reg != S_IDLE);
    assign scan_done = done_reg;
    assign slot_count = slots_reg;

    ////////////////////////////////////////////////////////////////////
    // Dwell pinned to the cycle; a loose window would hide a drift
    a_dwell_fixed: assert property (@(posedge clk) // RQ12
        disable iff (!reset_n)
        $rose(state_reg == S_HIGH) |-> ##49 state_reg == S_HIGH
        ##1 state_reg == S_LOW)
        else $error("dwell length wrong");
    a_fall_clamp: assert property (@(posedge clk) // RQ10
        disable iff (!reset_n)
        state_reg == S_HIGH ##1 state_reg == S_LOW |-> y_clamp[y_reg]
        && x_drive == '0)
        else $error("no clamp after falling drive edge");
    a_clamp_no_drive: assert property (@(posedge clk) // RQ10
        disable iff (!reset_n)
        y_clamp != '0 |-> x_drive == '0)
        else $error("receive line clamped while drive high");
    a_slot_match: assert property (@(posedge clk) // RQ3
        disable iff (!reset_n)
        scan_done |-> slot_count == live_count)
        else $error("timeslots differ from enabled keys");
    a_skip_off: assert property (@(posedge clk) disable iff (!reset_n) // RQ4
        state_reg == S_PICK && !key_enabled[cur_key] |=> state_reg != S_HIGH)
        else $error("burst on disabled key");
    a_key_number: assert property (@(posedge clk) disable iff (!reset_n) // RQ7
        result_valid |-> result_key == $past(cur_key))
        else $error("result key number mismatch");
    a_key_range: assert property (@(posedge clk) // RQ7
        disable iff (!reset_n)
        result_valid |-> result_key <= KEY_W'(NUM_KEYS - 1))
        else $error("result key outside grid");
    a_scan_origin: assert property (@(posedge clk) // RQ6
        disable iff (!reset_n)
        state_reg == S_IDLE && scan_start |=> x_reg == 3'h0 && y_reg == 2'h0)
        else $error("scan not starting at origin");
    a_one_burst: assert property (@(posedge clk) // RQ9
        disable iff (!reset_n)
        state_reg == S_RAMP |-> x_drive == '0
        && (timer_busy || timer_done))
        else $error("drive during conversion");
    a_done_idle: assert property (@(posedge clk) // RQ9
        disable iff (!reset_n)
        scan_done |-> !scan_busy && !result_valid)
        else $error("scan end flagged while still busy");
    a_burst_len: assert property (@(posedge clk) // RQ8
        disable iff (!reset_n)
        state_reg == S_PICK && state_next == S_HIGH |=>
        pulse_reg == $past(cur_burst))
        else $error("burst length not loaded");
    a_clamp_len: assert property (@(posedge clk) // RQ11
        disable iff (!reset_n)
        $rose(state_reg == S_CLAMP) |-> ##99 state_reg == S_CLAMP
        ##1 state_reg == S_RAMP)
        else $error("post-burst clamp length wrong");
    a_ramp_open: assert property (@(posedge clk) // RQ11
        disable iff (!reset_n)
        state_reg == S_RAMP |-> y_clamp == '0 && y_select[y_reg])
        else $error("receive line not released for ramp");
    a_single_line: assert property (@(posedge clk) // RQ1
        disable iff (!reset_n)
        $onehot0(x_drive) && $onehot0(y_clamp) && $onehot0(y_select))
        else $error("more than one matrix line active");
endmodule
`default_nettype wire

// ===== tmss_electrode_model.sv
`default_nettype none
// Key matrix with sample capacitors: the comparator trips after a ramp time
// that grows with the charge collected during the burst.
module tmss_electrode_model
    import tmss_pkg::*;
(
    input wire logic clk,
    input wire logic reset_n,
    input wire logic no_cross,
    input wire logic [tmss_pkg::NUM_X-1:0] x_drive,
    input wire logic [tmss_pkg::NUM_Y-1:0] y_clamp,
    input wire logic [tmss_pkg::NUM_Y-1:0] y_select,
    output logic zero_cross
);
    logic [15:0] ramp_reg;
    logic [8:0] pulse_reg;
    logic x_prev;
    logic ramping;

    // Line selected, unclamped and not driven: resistor ramp running
    assign ramping = (y_select != 3'h0) && (x_drive == 8'h00)
        && (y_clamp == 3'h0);
    // Stuck capacitor mode never crosses, to exercise saturation
    assign zero_cross = ramping && !no_cross
        && (ramp_reg >= 16'(10 + 3 * pulse_reg));

    always @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            ramp_reg <= 16'h0000;
            pulse_reg <= 9'h000;
            x_prev <= 1'b0;
        end else begin
            x_prev <= |x_drive;
            if (|x_drive && !x_prev) begin
                pulse_reg <= pulse_reg + 9'h001;
            end
            if (ramping) begin
                ramp_reg <= ramp_reg + 16'h0001;
            end else begin
                ramp_reg <= 16'h0000;
                // Guard: a short gap inside a burst must not drop charge
                if (ramp_reg > 16'h0002) begin
                    pulse_reg <= 9'h000;
                end
            end
        end
    end
endmodule
`default_nettype wire

// ===== touch_matrix_scan_sequencer_bench.sv
`default_nettype none
module touch_matrix_scan_sequencer_bench import tmss_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;
    typedef struct {logic [4:0] key; logic [7:0] burst; logic sat;} tmss_exp_s;
    logic clk = 1'b0;
    logic reset_n = 1'b0;
    logic large_variant = 1'b0;
    logic scan_start = 1'b0;
    logic no_cross = 1'b0;
    logic [191:0] dil = '0;
    logic [191:0] burst = '0;
    wire logic zero_cross;
    logic [7:0] x_drive;
    logic [2:0] y_clamp;
    logic [2:0] y_select;
    logic result_valid;
    logic [4:0] result_key;
    logic [15:0] result_data;
    logic scan_busy;
    logic scan_done;
    logic [4:0] slot_count;
    int fails = 0;
    int samples_checked = 0;
    logic [31:0] seed = 32'hD9B2BC36;
    tmss_exp_s exp_q[$];
    logic [4:0] done_q[$];
    tmss_exp_s e;
    logic [7:0] pulses;
    logic [7:0] hi_cnt;
    logic [7:0] x_prev;

    always #5 clk = ~clk;

    tmss_scan_sequencer uut (.clk(clk), .reset_n(reset_n),
        .large_variant(large_variant), .scan_start(scan_start),
        .detect_integrator_limit(dil), .burst_length_setting(burst),
        .zero_cross(zero_cross), .x_drive(x_drive), .y_clamp(y_clamp),
        .y_select(y_select), .result_valid(result_valid),
        .result_key(result_key), .result_data(result_data),
        .scan_busy(scan_busy), .scan_done(scan_done),
        .slot_count(slot_count));
    tmss_electrode_model matrix (.clk(clk), .reset_n(reset_n),
        .no_cross(no_cross), .x_drive(x_drive), .y_clamp(y_clamp),
        .y_select(y_select), .zero_cross(zero_cross));

    function automatic logic [31:0] xs(input logic [31:0] s);
        s = s ^ (s << 13);
        s = s ^ (s >> 17);
        s = s ^ (s << 5);
        return s;
    endfunction

    task automatic check(input string what, input logic [31:0] seen,
            input logic [31:0] expv);
        samples_checked++;
        if (seen !== expv) begin
            fails++;
            $display("MISMATCH %s expected %0h seen %0h", what, expv, seen);
        end
    endtask

    task automatic final_report();
        $display("checked %0d mismatches %0d", samples_checked, fails);
        if (fails == 0 && samples_checked > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////
    // Output watcher: burst shape per key, then results against notes
    always @(posedge clk) begin
        if (!reset_n) begin
            pulses <= 8'h00;
            hi_cnt <= 8'h00;
            x_prev <= 8'h00;
        end else begin
            x_prev <= x_drive;
            if (x_drive != 8'h00) hi_cnt <= hi_cnt + 8'h01;
            if (x_drive != 8'h00 && x_prev == 8'h00) begin
                pulses <= pulses + 8'h01;
                check("x_drive", x_drive, 8'h01 << exp_q[0].key[2:0]);
                check("y_select", y_select, 3'h1 << exp_q[0].key[4:3]);
            end
            if (x_drive == 8'h00 && x_prev != 8'h00) begin
                hi_cnt <= 8'h00;
                check("dwell", hi_cnt, DWELL_CYC);
                check("y_clamp", y_clamp, 3'h1 << exp_q[0].key[4:3]);
            end
            if (result_valid) begin
                if (exp_q.size() > 0) begin
                    e = exp_q.pop_front();
                end else begin
                    e = '{5'h1F, 8'h00, 1'b0};
                end
                pulses <= 8'h00;
                check("result_key", result_key, e.key);
                check("pulses", pulses, e.burst);
                if (e.sat) begin
                    check("result_data", result_data, RESULT_MAX);
                end else begin
                    check("ramp window", result_data >= 16'(7 + 3 * e.burst)
                        && result_data <= 16'(16 + 3 * e.burst), 1);
                end
            end
            if (scan_done) begin
                check("slot_count", slot_count, done_q.pop_front());
                check("left over", exp_q.size(), 0);
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    task automatic do_reset(input logic lv);
        @(posedge clk);
        reset_n <= 1'b0;
        large_variant <= lv;
        repeat (6) @(posedge clk);
        reset_n <= 1'b1;
        repeat (2) @(posedge clk);
    endtask

    // Random limits and burst lengths; off forces a zero limit
    task automatic fill(input int zeros, input logic [23:0] off);
        logic [191:0] d;
        logic [191:0] b;
        for (int k = 0; k < NUM_KEYS; k++) begin
            seed = xs(seed);
            d[k*8+:8] = off[k] ? 8'h00 : (seed[7:0] | 8'h01);
            b[k*8+:8] = 8'h01 + 8'(seed[9:8]);
            if (zeros != 0 && seed[12:10] == 3'h0) d[k*8+:8] = 8'h00;
            if (zeros != 0 && seed[15:13] == 3'h0) b[k*8+:8] = 8'h00;
        end
        @(posedge clk);
        dil <= d;
        burst <= b;
        repeat (2) @(posedge clk);
    endtask

    // Lowest key numbers win when more are enabled than the part allows
    task automatic scan(input logic sat, input logic retrig);
        int n;
        int lim;
        n = 0;
        lim = large_variant ? LIMIT_LARGE : LIMIT_SMALL;
        for (int k = 0; k < NUM_KEYS; k++) begin
            if (dil[k*8+:8] != 8'h00 && burst[k*8+:8] != 8'h00
                && n < lim) begin
                exp_q.push_back('{5'(k), burst[k*8+:8], sat});
                n++;
            end
        end
        done_q.push_back(5'(n));
        @(posedge clk);
        scan_start <= 1'b1;
        @(posedge clk);
        scan_start <= 1'b0;
        if (retrig) begin
            repeat (300) @(posedge clk);
            scan_start <= 1'b1;
            @(posedge clk);
            scan_start <= 1'b0;
        end
        for (int i = 0; i < 100000 && scan_done !== 1'b1; i++) @(negedge clk);
        check("scan_done", scan_done, 1);
        repeat (3) @(negedge clk);
        check("scan_busy", scan_busy, 0);
    endtask

    initial begin
        do_reset(1'b0);
        fill(0, 24'h000000);
        scan(1'b0, 1'b0);
        $display("test small part cap done");
        do_reset(1'b1);
        fill(1, 24'h000000);
        scan(1'b0, 1'b1);
        $display("test large part pared scan done");
        do_reset(1'b0);
        fill(0, 24'h00000F);
        scan(1'b0, 1'b0);
        $display("test third line swap done");
        no_cross <= 1'b1;
        fill(0, 24'hDFFFFF);
        scan(1'b1, 1'b0);
        $display("test ramp saturation done");
        final_report();
    end

    initial begin
        // Saturating key alone needs 65536 cycles; the rest about 19k
        repeat (100000) @(posedge clk);
        fails++;
        final_report();
    end
endmodule
`default_nettype wire
